/* File: common/isf_fmt_if.sv */
// Signals between the select pipeline and the format converter
`timescale 1ns/1ps
`default_nettype none
interface isf_fmt_if;
    logic [16:0] raw;
    logic        fixedMode;
    logic        offBin;
    logic [3:0]  fmt;
    logic [15:0] word;
    logic [1:0]  expo;
    modport fmtr (input raw, fixedMode, offBin, fmt, output word, expo);
    modport user (output raw, fixedMode, offBin, fmt, input word, expo);
endinterface
`default_nettype wire

/* File: common/isf_pkg.sv */
// Constants and types shared by the input select and format stage
package isf_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int NUM_BUS  = 4;
    localparam int BUS_W    = 17;
    localparam int WORD_W   = 16;
    localparam int ADDR_W   = 4;
    localparam int SHIFT_W  = 6;
    localparam int DLY_TAPS = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_TEST   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SHIFT  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_SRC_LSB    = 0;
    localparam int CTRL_TEST_BIT   = 2;
    localparam int CTRL_INTERP_BIT = 3;
    localparam int CTRL_OFFBIN_BIT = 4;
    localparam int CTRL_FIXED_BIT  = 5;
    localparam int CTRL_DLY_LSB    = 6;
    localparam int CTRL_FMT_LSB    = 9;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [BUS_W-1:0]   CTRL_RST  = 17'h00000;
    localparam logic [BUS_W-1:0]   TEST_RST  = 17'h00000;
    // Shift of 45 means the barrel shifter does not attenuate
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 6'h2D;

    // ------------------------------------------------------------
    // Floating formats, code is mode bits {17,16,8,7}
    // ------------------------------------------------------------
    localparam logic [3:0] FMT_11 = 4'h0;
    localparam logic [3:0] FMT_12 = 4'h1;
    localparam logic [3:0] FMT_13 = 4'h2;
    localparam logic [3:0] FMT_14 = 4'h3;
    localparam logic [2:0] MAXE_11 = 3'h5;
    localparam logic [2:0] MAXE_12 = 3'h4;
    localparam logic [2:0] MAXE_13 = 3'h3;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } isf_state_t;

endpackage

/* File: dv/isf_adc_model.sv */
// Converter model: framed sample words on four buses with first-word enable
`timescale 1ns/1ps
`default_nettype none
module isf_adc_model
(
    // Clock and frame request
    input  wire logic             ref_clk,
    input  wire logic             go,
    // Buses towards the block
    output logic      [3:0][16:0] sampleBus,
    output logic      [3:0]       busSampleEnableN
);
    logic [3:0] pos = 4'h0;

    initial sampleBus = '0;
    initial busSampleEnableN = 4'hF;

    always @(posedge ref_clk)
    begin
        for (int k = 0; k < 4; k++)
        begin
            // Between frames the word is released: inverted every clock, so the last frame word comes back on every other clock
            sampleBus[k] <= (go || pos != 4'h0) ? {11'h5A3, k[1:0], pos[2:0], 1'b0}
                                                 : ~sampleBus[k];
        end
        busSampleEnableN <= go ? 4'h0 : 4'hF;
        pos <= (go || (pos != 4'h0 && pos != 4'h7)) ? pos + 4'h1 : 4'h0;
    end
endmodule
`default_nettype wire

/* File: dv/test_input_select_format.sv */
// Self-checking testbench for the input select and format stage
`timescale 1ns/1ps
`default_nettype none
module test_input_select_format;
    logic             ref_clk = 1'b0;
    logic             arst_n = 1'b0;
    logic             clkEn = 1'b1;
    logic             globalSyncIn = 1'b0;
    logic             channelSyncIn = 1'b0;
    logic [3:0]       regAddr = 4'h0;
    logic [16:0]      regWrData = 17'h00000;
    logic             regWr = 1'b0;
    logic             regRd = 1'b0;
    logic             go = 1'b0;
    logic [16:0]      regRdData;
    logic [15:0]      sampleOut;
    logic             sampleValid;
    logic [5:0]       cicShift;
    logic [3:0][16:0] sampleBus;
    logic [3:0]       busSampleEnableN;
    logic [16:0]      v;
    logic             cntOn = 1'b0;
    int               n_fail = 0;
    int               samples_checked = 0;
    int               nV = 0;
    int               nNz = 0;

    always #5 ref_clk = ~ref_clk;

    isf_adc_model isf_adc_model_inst
    (
        .ref_clk          (ref_clk),
        .go               (go),
        .sampleBus        (sampleBus),
        .busSampleEnableN (busSampleEnableN)
    );

    isf_input_select_format isf_input_select_format_inst
    (
        .ref_clk          (ref_clk),
        .arst_n           (arst_n),
        .clkEn            (clkEn),
        .sampleBus        (sampleBus),
        .busSampleEnableN (busSampleEnableN),
        .globalSyncIn     (globalSyncIn),
        .channelSyncIn    (channelSyncIn),
        .regAddr          (regAddr),
        .regWrData        (regWrData),
        .regWr            (regWr),
        .regRd            (regRd),
        .regRdData        (regRdData),
        .sampleOut        (sampleOut),
        .sampleValid      (sampleValid),
        .cicShift         (cicShift)
    );

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (cntOn)
        begin
            nV += (sampleValid === 1'b1);
            nNz += (sampleValid === 1'b1 && sampleOut !== 16'h0000);
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_w(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            n_fail++;
            $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [16:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [16:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk_w(regRdData, exp);
    endtask

    // Two frames, so the second realigned sample is the one left standing
    task automatic run(input logic [16:0] exp);
        nV = 0;
        nNz = 0;
        cntOn = 1'b1;
        repeat (2)
        begin
            go <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (8) @(posedge ref_clk);
            #1;
        end
        cntOn = 1'b0;
        chk_w({1'b0, sampleOut}, exp);
    endtask

    task automatic bring_up(input bit useChan);
        wr(isf_pkg::ADDR_CTRL, cw(0, 0, 0, 0, 1, 0, 0));
        rd(isf_pkg::ADDR_SHIFT, 17'h0002D);
        rd(4'hF, 17'h00000);
        rd(isf_pkg::ADDR_STATUS, 17'h00000);
        run(17'h00000);
        chk_n(nV, 0);
        if (useChan)
            channelSyncIn <= 1'b1;
        else
            globalSyncIn <= 1'b1;
        @(posedge ref_clk);
        channelSyncIn <= 1'b0;
        globalSyncIn <= 1'b0;
        #1;
        run({1'b0, 11'h5A3, 5'h00});
        chk_n(nV, 2);
        $display("bring-up done");
    endtask

    function automatic logic [16:0] cw(input int sel, tst, itp, ob, fx, dly, fmt);
        return 17'((fmt << isf_pkg::CTRL_FMT_LSB) | (dly << isf_pkg::CTRL_DLY_LSB)
            | (fx << isf_pkg::CTRL_FIXED_BIT) | (ob << isf_pkg::CTRL_OFFBIN_BIT)
            | (itp << isf_pkg::CTRL_INTERP_BIT) | (tst << isf_pkg::CTRL_TEST_BIT) | sel);
    endfunction

    // Expected word for a floating sample; the exponent saturates per mode
    function automatic logic [16:0] fexp(input logic [3:0] f, input logic [16:0] s);
        logic [2:0] e;
        logic [2:0] mx;
        e = s[3:1];
        mx = (f == 4'h0) ? 3'h5 : (f == 4'h1) ? 3'h4 : 3'h3;
        if (e > mx)
            e = mx;
        if (f == 4'h3)
            return {1'b0, s[16:3], 2'b00};
        return {1'b0, 16'($signed({s[16:4], 3'b000}) >>> (mx - e))};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        rd(isf_pkg::ADDR_CTRL, 17'h00000);
        rd(isf_pkg::ADDR_TEST, 17'h00000);
        bring_up(1'b0);
        for (int k = 0; k < 4; k++)
        begin
            wr(isf_pkg::ADDR_CTRL, cw(k, 0, 0, 0, 1, 0, 0));
            run({1'b0, 11'h5A3, k[1:0], 3'h0});
            chk_n(nV, 2);
        end
        $display("bus select done");
        for (int d = 0; d < 8; d++)
        begin
            wr(isf_pkg::ADDR_CTRL, cw(0, 0, 0, 0, 1, d, 0));
            run({1'b0, 11'h5A3, 2'h0, d[2:0]});
        end
        $display("multiplex select done");
        wr(isf_pkg::ADDR_CTRL, cw(2, 0, 0, 1, 1, 0, 0));
        run({1'b0, 11'h1A3, 2'h2, 3'h0});
        $display("offset binary done");
        for (int f = 0; f < 4; f++)
        begin
            for (int e = 0; e < 8; e++)
            begin
                v = {13'h1A5B, e[2:0], 1'b0};
                wr(isf_pkg::ADDR_TEST, v);
                wr(isf_pkg::ADDR_CTRL, cw(1, 1, 0, 0, 0, 0, f));
                run(fexp(4'(f), v));
                chk_w({11'h000, cicShift}, 17'h0002D + ((f == 3) ? e[1:0] : 2'h0));
            end
        end
        // Last sample: fourteen-bit mode, exponent 3, gated so valid is low
        rd(isf_pkg::ADDR_STATUS, 17'h0000D);
        $display("floating formats done");
        // Upper bits of the write fall outside the six-bit shift field
        wr(isf_pkg::ADDR_SHIFT, 17'h1FFE0);
        rd(isf_pkg::ADDR_SHIFT, 17'h00020);
        clkEn <= 1'b0;
        wr(isf_pkg::ADDR_TEST, 17'h00000);
        clkEn <= 1'b1;
        rd(isf_pkg::ADDR_TEST, v);
        run(fexp(4'h3, v));
        chk_w({11'h000, cicShift}, 17'h00023);
        $display("test register hold done");
        wr(isf_pkg::ADDR_CTRL, cw(3, 0, 1, 0, 1, 0, 0));
        run(17'h00000);
        run(17'h00000);
        chk_n(nV, 18);
        chk_n(nNz, 2);
        rd(isf_pkg::ADDR_STATUS, 17'h00003);
        $display("interpolated done");
        arst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        arst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        rd(isf_pkg::ADDR_CTRL, 17'h00000);
        bring_up(1'b1);
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        $display("MISMATCH %0t run did not finish", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: verilog/isf_format.sv */
// Fixed and floating point sample to 16-bit word converter
`timescale 1ns/1ps
`default_nettype none
module isf_format
(
    // Format bus from the select pipeline
    isf_fmt_if.fmtr f
);
    // ------------------------------------------------------------
    // Bus bits 16..1 give word bits 15..0, the extra low bit is unused here
    // ------------------------------------------------------------
    wire        [15:0] x;
    wire signed [15:0] mant;
    wire        [2:0]  eMax;
    wire        [2:0]  eSat;
    wire        [2:0]  sh;
    wire signed [15:0] shifted;
    wire               is14;
    wire               isFloat3;

    // Sign flip first, so shifting and zeroing see two's complement
    assign x        = {f.raw[16] ^ f.offBin, f.raw[15:1]};
    assign mant     = {x[15:3], 3'h0};
    assign eMax     = (f.fmt == isf_pkg::FMT_11) ? isf_pkg::MAXE_11 :
                      (f.fmt == isf_pkg::FMT_12) ? isf_pkg::MAXE_12 :
                                                   isf_pkg::MAXE_13;
    assign eSat     = (x[2:0] > eMax) ? eMax : x[2:0];
    assign sh       = eMax - eSat;
    assign shifted  = mant >>> sh;
    assign is14     = (f.fmt == isf_pkg::FMT_14);
    assign isFloat3 = (f.fmt[3:2] == 2'h0) && !is14;

    // Reserved format codes pass the word through as fixed point
    assign f.word = f.fixedMode ? x :
                    is14        ? {x[15:2], 2'h0} :
                    isFloat3    ? shifted : x;
    // Gain of the two-bit exponent goes to the barrel shifter
    assign f.expo = (!f.fixedMode && is14) ? x[1:0] : 2'h0;
endmodule
`default_nettype wire

/* File: verilog/isf_input_select_format.sv */
// Per-channel input select, enable handling and format stage
//
// What this block does
// - Input comes from one of four sample buses or a test register.
// - Gated mode: one sample per clock with enable low, halt when high.
// - The enable travels down the pipeline with its data.
// - Interpolated mode: zero the sample when enable high, keep running.
// - After reset: gated mode, enables held off, nothing processed.
// - First global or channel sync releases the held enables.
// - Enable delayed 0..7 clocks loads the channel selection register.
// - Undelayed enable loads the next register, realigning channels.
// - Delay zero picks the first channel, seven the eighth.
// - Sample buses are 17 bits: fixed 16 or mantissa plus exponent.
// - Two's complement or offset binary, fixed or floating.
// - Fixed point: bit 15 weighs one, halving down to bit 0.
// - Floating: lowest two or three bits are the exponent.
// - Eleven-bit mode: shift by five minus exponent, saturate at five.
// - Twelve-bit mode: shift by four minus exponent, saturate at four.
// - Thirteen-bit mode: shift by three minus exponent, saturate at three.
// - Fourteen-bit mode: mantissa 15..2 and two zeros, no shift.
// - Later float gains go to the barrel shifter; 45 is unity.
// - Fourteen-bit mode is mode code 0,0,1,1.
`timescale 1ns/1ps
`default_nettype none
module isf_input_select_format
(
    // Clock, reset, clock enable
    input  wire logic                              ref_clk,
    input  wire logic                              arst_n,
    input  wire logic                              clkEn,
    // Sample buses from the converter
    input  wire logic [3:0][16:0]                  sampleBus,
    input  wire logic [3:0]                        busSampleEnableN,
    // Sync inputs
    input  wire logic                              globalSyncIn,
    input  wire logic                              channelSyncIn,
    // Register port
    input  wire logic [isf_pkg::ADDR_W-1:0]        regAddr,
    input  wire logic [isf_pkg::BUS_W-1:0]         regWrData,
    input  wire logic                              regWr,
    input  wire logic                              regRd,
    output logic      [isf_pkg::BUS_W-1:0]         regRdData,
    // Formatted sample towards the mixer
    output logic      [isf_pkg::WORD_W-1:0]        sampleOut,
    output logic                                   sampleValid,
    output logic      [isf_pkg::SHIFT_W-1:0]       cicShift
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    isf_pkg::isf_state_t               state_r;
    isf_pkg::isf_state_t               state_nxt;
    logic [isf_pkg::BUS_W-1:0]         ctrl_r;
    logic [isf_pkg::BUS_W-1:0]         test_r;
    logic [isf_pkg::SHIFT_W-1:0]       shift_r;
    logic [isf_pkg::DLY_TAPS-1:1]      enDly_r;
    logic [isf_pkg::BUS_W-1:0]         selReg_r;
    logic [isf_pkg::BUS_W-1:0]         realign_r;
    logic                              s1En_r;
    logic [isf_pkg::WORD_W-1:0]        sampleOut_r;
    logic                              sampleValid_r;
    logic [isf_pkg::SHIFT_W-1:0]       cicShift_r;
    logic [1:0]                        lastExp_r;
    logic [isf_pkg::BUS_W-1:0]         regRdData_r;

    isf_fmt_if fmtBus ();

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire                        wrCtrl;
    wire                        wrTest;
    wire                        wrShift;
    wire [1:0]                  srcSel;
    wire                        testSel;
    wire                        interp;
    wire                        offBin;
    wire                        fixedMode;
    wire [2:0]                  muxDly;
    wire [3:0]                  fmtCode;
    wire                        running;
    wire                        syncSeen;
    wire [isf_pkg::BUS_W-1:0]   selRaw;
    wire                        liveEn;
    wire [isf_pkg::DLY_TAPS-1:0] enTap;
    wire                        dlyEn;
    wire [isf_pkg::BUS_W-1:0]   rdMux;
    wire [isf_pkg::SHIFT_W-1:0] shiftSum;

    assign wrCtrl    = regWr && (regAddr == isf_pkg::ADDR_CTRL);
    assign wrTest    = regWr && (regAddr == isf_pkg::ADDR_TEST);
    assign wrShift   = regWr && (regAddr == isf_pkg::ADDR_SHIFT);
    assign srcSel    = ctrl_r[isf_pkg::CTRL_SRC_LSB +: 2];
    assign testSel   = ctrl_r[isf_pkg::CTRL_TEST_BIT];
    assign interp    = ctrl_r[isf_pkg::CTRL_INTERP_BIT];
    assign offBin    = ctrl_r[isf_pkg::CTRL_OFFBIN_BIT];
    assign fixedMode = ctrl_r[isf_pkg::CTRL_FIXED_BIT];
    assign muxDly    = ctrl_r[isf_pkg::CTRL_DLY_LSB +: 3];
    assign fmtCode   = ctrl_r[isf_pkg::CTRL_FMT_LSB +: 4];
    assign running   = (state_r == isf_pkg::ST_RUN);
    assign syncSeen  = globalSyncIn || channelSyncIn;

    // ------------------------------------------------------------
    // Source select and enable
    // ------------------------------------------------------------
    // Test source still follows the selected bus's enable
    assign selRaw = testSel ? test_r : sampleBus[srcSel];
    assign liveEn = running && !busSampleEnableN[srcSel];

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            isf_pkg::ST_HOLD:
            begin
                if (syncSeen)
                begin
                    state_nxt = isf_pkg::ST_RUN;
                end
            end
            isf_pkg::ST_RUN:
            begin
                state_nxt = isf_pkg::ST_RUN;
            end
            default:
            begin
                state_nxt = isf_pkg::ST_HOLD;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Enable delay line for demultiplexing
    // ------------------------------------------------------------
    // Relies on the source marking the first channel with a
    // one-clock enable; wider pulses would reload the selection.
    assign enTap[0] = liveEn;

    genvar gi;
    generate
        for (gi = 1; gi < isf_pkg::DLY_TAPS; gi++)
        begin : g_dly
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    enDly_r[gi] <= 1'b0;
                else if (clkEn)
                    enDly_r[gi] <= enTap[gi-1];
            end
            assign enTap[gi] = enDly_r[gi];
        end
    endgenerate

    assign dlyEn = enTap[muxDly];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    assign rdMux =
        (regAddr == isf_pkg::ADDR_CTRL)   ? ctrl_r :
        (regAddr == isf_pkg::ADDR_TEST)   ? test_r :
        (regAddr == isf_pkg::ADDR_SHIFT)  ? {11'h000, shift_r} :
        (regAddr == isf_pkg::ADDR_STATUS) ?
            {13'h0000, lastExp_r, sampleValid_r, running} :
        17'h00000;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r      <= isf_pkg::CTRL_RST;
            test_r      <= isf_pkg::TEST_RST;
            shift_r     <= isf_pkg::SHIFT_RST;
            regRdData_r <= 17'h00000;
        end
        else if (clkEn)
        begin
            if (wrCtrl)
                ctrl_r <= regWrData;
            if (wrTest)
                test_r <= regWrData;
            if (wrShift)
                shift_r <= regWrData[isf_pkg::SHIFT_W-1:0];
            regRdData_r <= regRd ? rdMux : 17'h00000;
        end
    end

    // ------------------------------------------------------------
    // Selection and realignment pipeline
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r   <= isf_pkg::ST_HOLD;
            selReg_r  <= 17'h00000;
            realign_r <= 17'h00000;
            s1En_r    <= 1'b0;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
            if (dlyEn)
                selReg_r <= selRaw;
            if (liveEn)
                realign_r <= selReg_r;
            s1En_r <= liveEn;
        end
    end

    // ------------------------------------------------------------
    // Format and output stage
    // ------------------------------------------------------------
    assign fmtBus.raw       = realign_r;
    assign fmtBus.fixedMode = fixedMode;
    assign fmtBus.offBin    = offBin;
    assign fmtBus.fmt       = fmtCode;
    assign shiftSum         = shift_r + {4'h0, fmtBus.expo};

    isf_format u_format
    (
        .f (fmtBus.fmtr)
    );

    // Interpolation zeroes after formatting, so offset binary zero
    // never leaks through as a full-scale negative value
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sampleOut_r   <= 16'h0000;
            sampleValid_r <= 1'b0;
            cicShift_r    <= isf_pkg::SHIFT_RST;
            lastExp_r     <= 2'h0;
        end
        else if (clkEn)
        begin
            sampleValid_r <= running && (interp || s1En_r);
            if (s1En_r)
            begin
                sampleOut_r <= fmtBus.word;
                cicShift_r  <= shiftSum;
                lastExp_r   <= fmtBus.expo;
            end
            else if (interp)
                sampleOut_r <= 16'h0000;
        end
    end

    assign sampleOut   = sampleOut_r;
    assign sampleValid = sampleValid_r;
    assign cicShift    = cicShift_r;
    assign regRdData   = regRdData_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_hold_quiet;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_r == isf_pkg::ST_HOLD) |=> !s1En_r;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("sample passed while inputs held");

    property p_sync_release;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && (state_r == isf_pkg::ST_HOLD) && syncSeen
        |=> (state_r == isf_pkg::ST_RUN);
    endproperty
    a_sync_release: assert property (p_sync_release)
        else $error("sync did not release inputs");

    property p_gated_halt;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && !interp && busSampleEnableN[srcSel]
        |=> (!s1En_r and (clkEn && !interp |=> !sampleValid));
    endproperty
    a_gated_halt: assert property (p_gated_halt)
        else $error("gated mode processed with enable high");

    property p_pipe_valid;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && running && !interp
        |=> (sampleValid == $past(s1En_r));
    endproperty
    a_pipe_valid: assert property (p_pipe_valid)
        else $error("valid not carried with its sample");

    property p_interp_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && running && interp && !s1En_r
        |=> (sampleOut == 16'h0000) && sampleValid;
    endproperty
    a_interp_zero: assert property (p_interp_zero)
        else $error("interpolated gap not zero");

    property p_sel_load;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && enTap[muxDly] |=> (selReg_r == $past(selRaw));
    endproperty
    a_sel_load: assert property (p_sel_load)
        else $error("selection register missed delayed enable");

    property p_dly_pick;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && liveEn && (muxDly == 3'h2) ##1 clkEn && !liveEn
        ##1 clkEn && !liveEn |=> (selReg_r == $past(selRaw));
    endproperty
    a_dly_pick: assert property (p_dly_pick)
        else $error("delay two did not pick third word");

    property p_realign;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && liveEn |=> (realign_r == $past(selReg_r));
    endproperty
    a_realign: assert property (p_realign)
        else $error("realign register missed enable");

    property p_test_src;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && testSel && dlyEn |=> (selReg_r == $past(test_r));
    endproperty
    a_test_src: assert property (p_test_src)
        else $error("test register not selected");

    property p_fixed_map;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && s1En_r && fixedMode && !offBin
        |=> (sampleOut == $past(realign_r[16:1]));
    endproperty
    a_fixed_map: assert property (p_fixed_map)
        else $error("fixed point weighting wrong");

    property p_fmt14;
        @(posedge ref_clk) disable iff (!arst_n)
        clkEn && s1En_r && !fixedMode && (fmtCode == isf_pkg::FMT_14)
        |=> (sampleOut[1:0] == 2'h0)
            && (cicShift == $past(shift_r) + {4'h0, $past(realign_r[2:1])});
    endproperty
    a_fmt14: assert property (p_fmt14)
        else $error("fourteen-bit mode word or gain wrong");

    c_release: cover property (@(posedge ref_clk) disable iff (!arst_n)
        (state_r == isf_pkg::ST_HOLD) ##1 (state_r == isf_pkg::ST_RUN));
    c_dly7: cover property (@(posedge ref_clk) disable iff (!arst_n)
        clkEn && (muxDly == 3'h7) && dlyEn);
    c_interp: cover property (@(posedge ref_clk) disable iff (!arst_n)
        interp && sampleValid && (sampleOut == 16'h0000));
    c_float11: cover property (@(posedge ref_clk) disable iff (!arst_n)
        s1En_r && !fixedMode && (fmtCode == isf_pkg::FMT_11));

endmodule
`default_nettype wire
